// [shared/usb_mux_pkg.sv]
// constants for the switch power control and detect/idle timing registers
//
// Operation
// - control bit 1 switches the internal power MOSFET off (0) or on (1).
// - power switch bit resets to 1 when bus supply voltage is present.
// - writing 1 to control bit 2 soft-resets the device; writing 0 does nothing.
// - after soft reset, set reset-occurred flag and self-clear the request bit.
// - auto sleep enable at 1 detects sleep automatically, ignoring host sleep commands.
// - auto sleep enable at 0 disables detection; only host commands enter sleep.
// - control bit 6 closes left speaker to data-minus switch; resets open.
// - control bit 7 gates host access to test registers 0x24 to 0x26.
// - control bits 0, 3, 4 are reserved read/write bits resetting to 0.
// - timing bits 3-0 select delay from bus voltage to accessory identification.
// - timing bits 7-4 select switch inactivity time, reset code 1001 is 10 s.
// - with audio or TTY attached, enter sleep after selected inactivity time.
// - mode bit 0 reads 1 after any reset and clears when read.
// - mode bit 2 shows whether the device is in sleep.
package usb_mux_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h1B;
	localparam logic [7:0] ADDR_TIMING = 8'h1C;
	localparam logic [7:0] ADDR_MODE = 8'h1D;
	localparam logic [7:0] ADDR_TEST_FIRST = 8'h24;
	localparam logic [7:0] ADDR_TEST_LAST = 8'h26;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_POWER_SWITCH_ON = 1;
	localparam int BIT_SOFT_RESET = 2;
	localparam int BIT_AUTO_SLEEP_ENABLE = 5;
	localparam int BIT_LEFT_SPEAKER_MINUS_SWITCH = 6;
	localparam int BIT_TEST_BANK_UNLOCK = 7;
	localparam logic [7:0] CONTROL_RESERVED_MASK = 8'h19;
	localparam int ID_DELAY_LSB = 0;
	localparam int IDLE_TIME_LSB = 4;
	localparam int BIT_RESET_OCCURRED = 0;
	localparam int BIT_ACTIVE = 1;
	localparam int BIT_SLEEP_STATE = 2;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] CONTROL_RESET = 8'h20;
	localparam logic [3:0] ID_DELAY_RESET = 4'h4;
	localparam logic [3:0] IDLE_TIME_RESET = 4'h9;
	localparam logic [1:0] STRAP_WAIT_RESET = 2'h3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_TICK_TIME_NS = 1000000;
	localparam int MS_TICK_CYCLES = MS_TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int ID_DELAY_STEP_MS = 100;
	localparam int IDLE_STEP_MS = 1000;
	localparam int TIMER_WIDTH = 14;
	localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;

	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SOFT_RESET = 2'b10
	} ctrl_state_t;

endpackage

// [hdl/interval_timer.sv]
// millisecond interval timer with a programmable limit
`timescale 1ns/1ps
module interval_timer
	import usb_mux_pkg::*;
#(
	parameter int W = TIMER_WIDTH
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic msTick,
	input wire logic restart,
	input wire logic run,
	input wire logic [W-1:0] limitMs,
	output logic fired,
	output logic expired
);

	logic [W-1:0] count_reg;
	logic expired_reg;
	wire atLimit = (count_reg == limitMs - W'(1));
	wire counting = run && !restart && !expired_reg;

	assign fired = counting && msTick && atLimit;
	assign expired = expired_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= '0;
			expired_reg <= 1'b0;
		end else if (restart || !run) begin
			count_reg <= '0;
			expired_reg <= 1'b0;
		end else if (fired) begin
			expired_reg <= 1'b1;
		end else if (counting && msTick) begin
			count_reg <= count_reg + W'(1);
		end
	end

endmodule

// [hdl/usb_mux_control_timing_regs.sv]
// control, timing and device mode registers with detect delay and auto sleep
`timescale 1ns/1ps
module usb_mux_control_timing_regs
	import usb_mux_pkg::*;
#(
	parameter int MS_TICK_CYCLES_P = MS_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic busVoltage,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	input wire logic [7:0] testRegRdata,
	output logic testRegSelect,
	input wire logic switchActivity,
	input wire logic audioOrTtyAttached,
	output logic powerSwitchOn,
	output logic leftSpeakerMinusSwitch,
	output logic sleepState,
	output logic softResetActive,
	output logic startAccessoryId
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [TIMER_WIDTH-1:0] stepsToMs(input logic [3:0] code, input int step);
		stepsToMs = TIMER_WIDTH'((int'(code) + 1) * step);
	endfunction

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic busMeta_reg, busSync_reg, busPrev_reg;
	logic [7:0] control_reg, control_next;
	logic [3:0] idDelay_reg, idDelay_next;
	logic [3:0] idleTime_reg, idleTime_next;
	logic resetOccurred_reg, resetOccurred_next;
	logic active_reg, active_next;
	logic sleep_reg, sleep_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [1:0] strapWait_reg;
	logic [2:0] srCount_reg;
	logic [31:0] tickCount_reg;
	logic msTick_reg;
	ctrl_state_t state_reg, state_next;
	logic idFired, idleFired;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire inSoftReset = (state_reg == ST_SOFT_RESET);
	wire srDone = inSoftReset && (srCount_reg == SOFT_RESET_CYCLES - 3'h1);
	wire hostWrite = regWrite && !inSoftReset;
	wire hostRead = regRead && !inSoftReset;
	wire wrControl = hostWrite && (regAddr == ADDR_CONTROL);
	wire wrTiming = hostWrite && (regAddr == ADDR_TIMING);
	wire wrMode = hostWrite && (regAddr == ADDR_MODE);
	wire rdMode = hostRead && (regAddr == ADDR_MODE);
	wire inTestRange = (regAddr >= ADDR_TEST_FIRST) && (regAddr <= ADDR_TEST_LAST);
	wire testUnlocked = control_reg[BIT_TEST_BANK_UNLOCK];
	wire softResetRequest = wrControl && regWdata[BIT_SOFT_RESET];
	wire autoSleep = control_reg[BIT_AUTO_SLEEP_ENABLE];
	wire strapLoad = (strapWait_reg == 2'h1);
	wire busRise = busSync_reg && !busPrev_reg;
	wire idleRun = autoSleep && audioOrTtyAttached && !sleep_reg;
	wire hostSleepWrite = wrMode && !autoSleep;

	assign testRegSelect = (regWrite || regRead) && inTestRange && testUnlocked && !inSoftReset;
	assign powerSwitchOn = control_reg[BIT_POWER_SWITCH_ON];
	assign leftSpeakerMinusSwitch = control_reg[BIT_LEFT_SPEAKER_MINUS_SWITCH];
	assign sleepState = sleep_reg;
	assign softResetActive = inSoftReset;
	assign startAccessoryId = idFired;
	assign regRdata = rdata_reg;

	// ----------------------------------------------------------------
	// bus voltage synchroniser and power-up strap capture
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			busMeta_reg <= 1'b0;
			busSync_reg <= 1'b0;
			busPrev_reg <= 1'b0;
			strapWait_reg <= STRAP_WAIT_RESET;
		end else begin
			busMeta_reg <= busVoltage;
			busSync_reg <= busMeta_reg;
			busPrev_reg <= busSync_reg;
			if (strapWait_reg != 2'h0) begin
				strapWait_reg <= strapWait_reg - 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// millisecond tick
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tickCount_reg <= '0;
			msTick_reg <= 1'b0;
		end else if (tickCount_reg == 32'(MS_TICK_CYCLES_P - 1)) begin
			tickCount_reg <= '0;
			msTick_reg <= 1'b1;
		end else begin
			tickCount_reg <= tickCount_reg + 32'h1;
			msTick_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// soft reset sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_RUN: begin
				if (softResetRequest) begin
					state_next = ST_SOFT_RESET;
				end
			end
			ST_SOFT_RESET: begin
				if (srDone) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_RUN;
			srCount_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			srCount_reg <= inSoftReset ? srCount_reg + 3'h1 : 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// register next values
	// ----------------------------------------------------------------
	always_comb begin
		control_next = control_reg;
		idDelay_next = idDelay_reg;
		idleTime_next = idleTime_reg;
		active_next = active_reg;
		if (inSoftReset) begin
			// hold documented reset values while the soft reset runs
			control_next = CONTROL_RESET | 8'(1 << BIT_SOFT_RESET);
			control_next[BIT_POWER_SWITCH_ON] = busSync_reg;
			idDelay_next = ID_DELAY_RESET;
			idleTime_next = IDLE_TIME_RESET;
			active_next = 1'b0;
			if (srDone) begin
				control_next[BIT_SOFT_RESET] = 1'b0;
			end
		end else begin
			if (strapLoad) begin
				control_next[BIT_POWER_SWITCH_ON] = busSync_reg;
			end
			if (softResetRequest) begin
				// a reset request moves no switch before the reset takes over
				control_next[BIT_SOFT_RESET] = 1'b1;
			end else if (wrControl) begin
				control_next = regWdata;
			end
			if (wrTiming) begin
				idDelay_next = regWdata[ID_DELAY_LSB +: 4];
				idleTime_next = regWdata[IDLE_TIME_LSB +: 4];
			end
			if (wrMode) begin
				active_next = regWdata[BIT_ACTIVE];
			end
		end
	end

	always_comb begin
		resetOccurred_next = resetOccurred_reg;
		if (rdMode) begin
			resetOccurred_next = 1'b0;
		end
		if (srDone) begin
			resetOccurred_next = 1'b1;
		end
	end

	always_comb begin
		sleep_next = sleep_reg;
		if (hostSleepWrite) begin
			sleep_next = regWdata[BIT_SLEEP_STATE];
		end
		if (autoSleep && switchActivity) begin
			sleep_next = 1'b0;
		end
		if (idleFired) begin
			sleep_next = 1'b1;
		end
		if (inSoftReset) begin
			sleep_next = 1'b0;
		end
	end

	always_comb begin
		rdata_next = 8'h00;
		if (inTestRange && testUnlocked) begin
			rdata_next = testRegRdata;
		end else if (regAddr == ADDR_CONTROL) begin
			rdata_next = control_reg;
		end else if (regAddr == ADDR_TIMING) begin
			rdata_next = {idleTime_reg, idDelay_reg};
		end else if (regAddr == ADDR_MODE) begin
			rdata_next = {5'h00, sleep_reg, active_reg, resetOccurred_reg};
		end
	end

	// ----------------------------------------------------------------
	// register storage
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			control_reg <= CONTROL_RESET;
			idDelay_reg <= ID_DELAY_RESET;
			idleTime_reg <= IDLE_TIME_RESET;
			resetOccurred_reg <= 1'b1;
			active_reg <= 1'b0;
			sleep_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			control_reg <= control_next;
			idDelay_reg <= idDelay_next;
			idleTime_reg <= idleTime_next;
			resetOccurred_reg <= resetOccurred_next;
			active_reg <= active_next;
			sleep_reg <= sleep_next;
			if (hostRead) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// detect delay and inactivity timers
	// ----------------------------------------------------------------
	interval_timer #(
		.W(TIMER_WIDTH)
	) idDelayTimer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.msTick(msTick_reg),
		.restart(busRise || inSoftReset),
		.run(busSync_reg),
		.limitMs(stepsToMs(idDelay_reg, ID_DELAY_STEP_MS)),
		.fired(idFired),
		.expired()
	);

	interval_timer #(
		.W(TIMER_WIDTH)
	) idleTimer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.msTick(msTick_reg),
		.restart(switchActivity || inSoftReset),
		.run(idleRun),
		.limitMs(stepsToMs(idleTime_reg, IDLE_STEP_MS)),
		.fired(idleFired),
		.expired()
	);

endmodule

// [sim/usb_mux_control_timing_regs_assertions.sv]
// ----------------------------------------------------------------
// port checks for the control and timing register block
// ----------------------------------------------------------------
`timescale 1ns/1ps
module usb_mux_control_timing_regs_checker
	import usb_mux_pkg::*;
#(
	parameter int MS_TICK_CYCLES_P = MS_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic busVoltage,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic [7:0] testRegRdata,
	input wire logic testRegSelect,
	input wire logic switchActivity,
	input wire logic audioOrTtyAttached,
	input wire logic powerSwitchOn,
	input wire logic leftSpeakerMinusSwitch,
	input wire logic sleepState,
	input wire logic softResetActive,
	input wire logic startAccessoryId
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);
	wire logic ctrlWr = regWrite && regAddr == ADDR_CONTROL && !softResetActive;
	wire logic plainWr = ctrlWr && !regWdata[2];
	wire logic testAddr = regAddr >= ADDR_TEST_FIRST && regAddr <= ADDR_TEST_LAST;
	wire logic wrPower = regWdata[1];
	wire logic wrSpeaker = regWdata[6];
	// model of the test bank unlock bit, cleared by any reset
	logic unlockSeen;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			unlockSeen <= 1'b0;
		end else if (softResetActive) begin
			unlockSeen <= 1'b0;
		end else if (plainWr) begin
			unlockSeen <= regWdata[7];
		end
	end
	chk_power_write: assert property (plainWr |=> powerSwitchOn == $past(wrPower))
		else $error("power switch not taken from write");
	chk_speaker_write: assert property (plainWr |=> leftSpeakerMinusSwitch == $past(wrSpeaker))
		else $error("speaker switch not taken from write");
	chk_soft_reset_go: assert property (ctrlWr && regWdata[2] |=> softResetActive)
		else $error("soft reset not started");
	chk_zero_no_reset: assert property (plainWr |=> !softResetActive)
		else $error("soft reset without request");
	chk_soft_reset_len: assert property ($rose(softResetActive) |-> softResetActive[*4] ##1 !softResetActive)
		else $error("soft reset length wrong");
	chk_test_gate: assert property (testRegSelect |-> (regRead || regWrite) && testAddr && !softResetActive && unlockSeen)
		else $error("test bank selected wrongly");
	chk_test_open: assert property ((regRead || regWrite) && testAddr && !softResetActive && unlockSeen |-> testRegSelect)
		else $error("unlocked test bank not selected");
	chk_test_locked: assert property (regRead && testAddr && !softResetActive && !unlockSeen |=> regRdata == 8'h00)
		else $error("locked test bank readable");
	chk_reset_hold: assert property (ctrlWr && regWdata[2] |=> $stable(leftSpeakerMinusSwitch) && $stable(powerSwitchOn))
		else $error("reset request moved a switch");
	chk_sleep_cleared: assert property ($fell(softResetActive) |-> !sleepState)
		else $error("sleep kept over soft reset");
	chk_id_pulse: assert property (startAccessoryId |=> !startAccessoryId[*8])
		else $error("identification start repeats");
	chk_reset_state: assert property ($rose(nrst) |-> !leftSpeakerMinusSwitch && !sleepState)
		else $error("bad state after reset");
endmodule
bind usb_mux_control_timing_regs usb_mux_control_timing_regs_checker #(
	.MS_TICK_CYCLES_P(MS_TICK_CYCLES_P)
) usb_mux_control_timing_regs_checker_inst (
	.sys_clk(sys_clk), .nrst(nrst), .busVoltage(busVoltage), .regWrite(regWrite),
	.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
	.testRegRdata(testRegRdata), .testRegSelect(testRegSelect),
	.switchActivity(switchActivity), .audioOrTtyAttached(audioOrTtyAttached),
	.powerSwitchOn(powerSwitchOn), .leftSpeakerMinusSwitch(leftSpeakerMinusSwitch),
	.sleepState(sleepState), .softResetActive(softResetActive),
	.startAccessoryId(startAccessoryId)
);

// [sim/host_bus.sv]
// ----------------------------------------------------------------
// host register access model with a test bank responder
// ----------------------------------------------------------------
`timescale 1ns/1ps
module host_bus (
	input wire logic sys_clk,
	input wire logic [7:0] regRdata,
	input wire logic testRegSelect,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWdata,
	output logic [7:0] testRegRdata
);
	// bank data only while selected
	assign testRegRdata = testRegSelect ? 8'h5A : 8'hA5;
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
	end
	// soft reset is only asked for by register writes; sleep also by the idle timer in auto sleep
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		#1;
		regAddr = addr;
		regWdata = data;
		regWrite = 1'b1;
		@(posedge sys_clk);
		#1;
		regWrite = 1'b0;
		regWdata = ~data;
	endtask
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk);
		#1;
		regAddr = addr;
		regRead = 1'b1;
		@(posedge sys_clk);
		#1;
		data = regRdata;
		regRead = 1'b0;
	endtask
endmodule

// [sim/test_usb_mux_control_timing_regs.sv]
// ----------------------------------------------------------------
// self-checking bench for the control and timing register block
// ----------------------------------------------------------------
`timescale 1ns/1ps
module test_usb_mux_control_timing_regs
	import usb_mux_pkg::*;
;
	localparam int MS = 10;
	typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} row_t;
	row_t rows [7] = '{'{ADDR_CONTROL, 8'hDB, 8'hDB}, '{8'h25, 8'h00, 8'h5A},
		'{ADDR_CONTROL, 8'h20, 8'h20}, '{8'h26, 8'h00, 8'h00}, '{8'h40, 8'hFF, 8'h00},
		'{ADDR_TIMING, 8'hFF, 8'hFF}, '{ADDR_TIMING, 8'h00, 8'h00}};
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic busVoltage = 1'b1;
	logic switchActivity = 1'b0;
	logic audioOrTtyAttached = 1'b0;
	wire logic regWrite, regRead, testRegSelect, powerSwitchOn, leftSpeakerMinusSwitch;
	wire logic sleepState, softResetActive, startAccessoryId;
	wire logic [7:0] regAddr, regWdata, regRdata, testRegRdata;
	int nErrors = 0;
	int samplesChecked = 0;
	int n;
	logic [7:0] rd;
	always #5 sys_clk = ~sys_clk;
	usb_mux_control_timing_regs #(.MS_TICK_CYCLES_P(MS)) usb_mux_control_timing_regs_inst (
		.sys_clk(sys_clk), .nrst(nrst), .busVoltage(busVoltage), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.testRegRdata(testRegRdata), .testRegSelect(testRegSelect),
		.switchActivity(switchActivity), .audioOrTtyAttached(audioOrTtyAttached),
		.powerSwitchOn(powerSwitchOn), .leftSpeakerMinusSwitch(leftSpeakerMinusSwitch),
		.sleepState(sleepState), .softResetActive(softResetActive),
		.startAccessoryId(startAccessoryId));
	host_bus host_bus_inst (.sys_clk(sys_clk), .regRdata(regRdata),
		.testRegSelect(testRegSelect), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .testRegRdata(testRegRdata));
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		samplesChecked++;
		if (seen !== want) begin
			nErrors++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic rdchk(input logic [7:0] addr, input logic [7:0] want);
		host_bus_inst.read_reg(addr, rd);
		check(rd, want);
	endtask
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		host_bus_inst.write_reg(addr, data);
	endtask
	task automatic giveVerdict();
		if (nErrors == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// count n in [lo, hi); reaching hi is a hang and ends the run
	task automatic window(input int lo, input int hi);
		if (n >= hi) begin
			nErrors++;
			giveVerdict();
		end else begin
			check({7'h00, n >= lo}, 8'h01);
		end
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		check({7'h00, powerSwitchOn}, 8'h01);
		rdchk(ADDR_CONTROL, 8'h22);
		rdchk(ADDR_TIMING, 8'h94);
		rdchk(ADDR_MODE, 8'h01);
		rdchk(ADDR_MODE, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].data);
			rdchk(rows[i].addr, rows[i].exp);
			if (rows[i].addr == ADDR_CONTROL)
				check({6'h00, leftSpeakerMinusSwitch, powerSwitchOn}, {6'h00, rows[i].exp[6], rows[i].exp[1]});
		end
		wr(ADDR_MODE, 8'h04);
		check({7'h00, sleepState}, 8'h00);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_MODE, 8'h04);
		check({7'h00, sleepState}, 8'h01);
		wr(ADDR_MODE, 8'h00);
		check({7'h00, sleepState}, 8'h00);
		busVoltage = 1'b0;
		repeat (5) @(posedge sys_clk);
		#1;
		busVoltage = 1'b1;
		n = 0;
		while (startAccessoryId !== 1'b1 && n < 101 * MS + 6) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		window(99 * MS, 101 * MS + 6);
		wr(ADDR_CONTROL, 8'h20);
		audioOrTtyAttached = 1'b1;
		switchActivity = 1'b1;
		@(posedge sys_clk);
		#1;
		switchActivity = 1'b0;
		n = 0;
		while (sleepState !== 1'b1 && n < 1001 * MS + 6) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		window(999 * MS, 1001 * MS + 6);
		switchActivity = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		switchActivity = 1'b0;
		check({7'h00, sleepState}, 8'h00);
		wr(ADDR_TIMING, 8'h3C);
		wr(ADDR_CONTROL, 8'hC4);
		check({7'h00, softResetActive}, 8'h01);
		n = 0;
		while (softResetActive !== 1'b0 && n < 5) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		window(4, 5);
		rdchk(ADDR_CONTROL, 8'h22);
		rdchk(ADDR_TIMING, 8'h94);
		rdchk(ADDR_MODE, 8'h01);
		check({7'h00, leftSpeakerMinusSwitch}, 8'h00);
		// reset in mid-run with the bus supply absent
		wr(ADDR_CONTROL, 8'hC0);
		busVoltage = 1'b0;
		nrst = 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		check({7'h00, powerSwitchOn}, 8'h00);
		rdchk(ADDR_CONTROL, 8'h20);
		rdchk(ADDR_MODE, 8'h01);
		wr(ADDR_MODE, 8'h06);
		rdchk(ADDR_MODE, 8'h02);
		giveVerdict();
	end
endmodule
